// ### osr_clock_front.sv
`timescale 1ns/1ps
`default_nettype none
`include "osr_params.svh"

module osr_clock_front
#(
   parameter int unsigned STARTUP_CYCLES = `OSR_STARTUP_CYCLES
)
(
   // clock, reset, enable
   input  wire logic                clock_in,
   input  wire logic                rst_n_in,
   input  wire logic                clk_en_in,
   // register bus
   input  wire osr_pkg::osr_wb_req_s wb_req_in,
   output logic [31:0]              wb_dat_out,
   output logic                     wb_ack_out,
   // configuration words and restart events
   input  wire osr_pkg::osr_cfg_s   cfg_in,
   input  wire logic                brown_out_in,
   input  wire logic                sleep_in,
   // raw oscillators and pll lock, all asynchronous
   input  wire logic                primary_osc_in,
   input  wire logic                secondary_osc_in,
   input  wire logic                rc_osc_in,
   input  wire logic                pll_locked_in,
   input  wire logic                secondary_enable_in,
   // instruction clock and port logic behind the pins
   input  wire logic                instruction_clock_in,
   input  wire osr_pkg::osr_gpio_s  osc_input_port_in,
   input  wire osr_pkg::osr_gpio_s  osc_output_port_in,
   output logic                     osc_input_port_data_out,
   output logic                     osc_output_port_data_out,
   // osc_input_pin
   input  wire logic                osc_input_pin_in,
   output logic                     osc_input_pin_out,
   output logic                     osc_input_pin_oe_n_out,
   // osc_output_pin
   input  wire logic                osc_output_pin_in,
   output logic                     osc_output_pin_out,
   output logic                     osc_output_pin_oe_n_out,
   // clock outputs toward switch and pll logic
   output logic                     sys_clock_tick_out,
   output logic                     pll_ref_tick_out,
   output logic                     rc_post_tick_out,
   output logic                     pll_path_out,
   output logic                     clock_ready_out,
   output logic                     primary_ready_out,
   output logic                     secondary_ready_out,
   output logic                     pll_lock_out,
   output logic [`OSR_TUNE_MSB:0]   rc_tune_out
);

   // ***************************************************
   // helper functions
   // ***************************************************
   // postscaler divide ratio for a select code
   function automatic logic [8:0] post_ratio(input logic [2:0] code);
      logic [8:0] r;
      r = 9'h001 << code;
      if (code == 3'h7)
      begin
         r = 9'h100;
      end
      return r;
   endfunction : post_ratio

   // true for source codes that route through the pll
   function automatic logic uses_pll(input logic [2:0] src);
      return (src == `OSR_SRC_RC_PLL) || (src == `OSR_SRC_PRI_PLL);
   endfunction : uses_pll

   // ***************************************************
   // input synchronisers
   // ***************************************************
   localparam int unsigned NS = 6;
   logic [NS-1:0] raw_w;
   logic [NS-1:0] sync1_reg;
   logic [NS-1:0] sync2_reg;
   logic [NS-1:0] sync3_reg;
   logic [NS-1:0] filt_reg;
   logic [NS-1:0] filt_d_reg;
   logic [NS-1:0] agree_w;
   logic [NS-1:0] filt_next;
   logic [NS-1:0] rise_w;

   assign raw_w = {osc_output_pin_in, osc_input_pin_in, pll_locked_in,
                   rc_osc_in, secondary_osc_in, primary_osc_in};
   // a change only counts once stages two and three agree
   assign agree_w   = ~(sync2_reg ^ sync3_reg);
   assign filt_next = (agree_w & sync3_reg) | (~agree_w & filt_reg);
   assign rise_w    = filt_reg & ~filt_d_reg;

   // three stages, then a filtered copy and its delay for edges
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         sync1_reg  <= '0;
         sync2_reg  <= '0;
         sync3_reg  <= '0;
         filt_reg   <= '0;
         filt_d_reg <= '0;
      end
      else if (clk_en_in)
      begin
         sync1_reg  <= raw_w;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         filt_reg   <= filt_next;
         filt_d_reg <= filt_reg;
      end
   end

   logic pri_edge_w;
   logic sec_edge_w;
   logic rc_edge_w;
   logic pll_lock_sync_w;

   // edges only appear once the swing crosses the pin thresholds
   assign pri_edge_w      = rise_w[0];
   assign sec_edge_w      = rise_w[1];
   assign rc_edge_w       = rise_w[2];
   assign pll_lock_sync_w = filt_reg[3];

   // ***************************************************
   // configuration capture after reset release
   // ***************************************************
   logic            cfg_loaded_reg;
   osr_pkg::osr_cfg_s cfg_reg;
   logic            load_w;

   assign load_w = clk_en_in && !cfg_loaded_reg;

   // configuration words are sampled once, the cycle after reset
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         cfg_loaded_reg <= 1'b0;
         cfg_reg        <= '0;
      end
      else if (load_w)
      begin
         cfg_loaded_reg <= 1'b1;
         cfg_reg        <= cfg_in;
      end
   end

   logic [1:0] mode_w;
   logic       crystal_w;
   logic       ext_w;
   logic       pri_off_w;

   // primary mode field decode
   assign mode_w    = cfg_reg.primary_osc_mode_cfg;
   assign crystal_w = (mode_w == `OSR_MODE_MED) || (mode_w == `OSR_MODE_HIGH);
   assign ext_w     = (mode_w == `OSR_MODE_EXT);
   assign pri_off_w = (mode_w == `OSR_MODE_OFF);

   // ***************************************************
   // start-up timers
   // ***************************************************
   logic sleep_d_reg;
   logic restart_w;
   logic pri_ready_w;
   logic sec_ready_w;

   // restart on reset load, brown-out and the end of sleep
   assign restart_w = load_w || brown_out_in || (sleep_d_reg && !sleep_in);

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         sleep_d_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         sleep_d_reg <= sleep_in;
      end
   end

   // one timer per crystal oscillator, each gated on its own
   osr_startup_timer #(.CYCLES(STARTUP_CYCLES)) u_pri_timer
   (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .clk_en_in   (clk_en_in),
      .enable_in   (cfg_loaded_reg && !pri_off_w && !sleep_in),
      .restart_in  (restart_w),
      .bypass_in   (ext_w),
      .osc_edge_in (pri_edge_w),
      .ready_out   (pri_ready_w)
   );

   osr_startup_timer #(.CYCLES(STARTUP_CYCLES)) u_sec_timer
   (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .clk_en_in   (clk_en_in),
      .enable_in   (cfg_loaded_reg && secondary_enable_in && !sleep_in),
      .restart_in  (restart_w),
      .bypass_in   (1'b0),
      .osc_edge_in (sec_edge_w),
      .ready_out   (sec_ready_w)
   );

   // ***************************************************
   // register bus slave
   // ***************************************************
   logic       ack_reg;
   logic [31:0] dat_reg;
   logic [2:0] post_sel_reg;
   logic [`OSR_TUNE_MSB:0] tune_reg;
   logic [2:0] src_reg;
   logic       lock_reg;
   logic       req_w;
   logic       wr_w;
   logic       wr_div_w;
   logic       wr_tune_w;
   logic       wr_sw_w;
   logic [31:0] rd_w;
   logic [31:0] status_w;
   logic       src_ready_w;

   // a write lands at the edge the master sees ack
   assign req_w     = wb_req_in.cyc && wb_req_in.stb;
   assign wr_w      = req_w && wb_req_in.we && ack_reg;
   assign wr_div_w  = wr_w && (wb_req_in.adr == `OSR_ADDR_CLOCK_DIVISOR_REG) && wb_req_in.sel[1];
   assign wr_tune_w = wr_w && (wb_req_in.adr == `OSR_ADDR_TUNE) && wb_req_in.sel[0];
   assign wr_sw_w   = wr_w && (wb_req_in.adr == `OSR_ADDR_SWITCH) && wb_req_in.sel[0];

   assign status_w = {21'h000000, cfg_reg.initial_source_cfg, 1'b0, cfg_reg.osc_output_pin_pin_function_cfg,
                      mode_w, lock_reg, sec_ready_w, pri_ready_w, clock_ready_out};

   // read mux, unmapped offsets read as zero
   assign rd_w = (wb_req_in.adr == `OSR_ADDR_CLOCK_DIVISOR_REG) ? {21'h000000, post_sel_reg, 8'h00} :
                 (wb_req_in.adr == `OSR_ADDR_TUNE)   ? {26'h0000000, tune_reg} :
                 (wb_req_in.adr == `OSR_ADDR_SWITCH) ? {29'h00000000, src_reg} :
                 (wb_req_in.adr == `OSR_ADDR_STATUS) ? status_w : 32'h00000000;

   // single-wait-state answer; ack drops the cycle after it rose
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else if (clk_en_in)
      begin
         ack_reg <= req_w && !ack_reg;
         dat_reg <= rd_w;
      end
   end

   // control registers; the source follows the config words at power-on
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         post_sel_reg <= `OSR_POST_RESET;
         tune_reg     <= `OSR_TUNE_RESET;
         src_reg      <= `OSR_SRC_RC;
      end
      else if (clk_en_in)
      begin
         if (wr_div_w)
         begin
            post_sel_reg <= wb_req_in.dat[`OSR_POST_MSB:`OSR_POST_LSB];
         end
         if (wr_tune_w)
         begin
            tune_reg <= wb_req_in.dat[`OSR_TUNE_MSB:0];
         end
         if (load_w)
         begin
            src_reg <= cfg_in.initial_source_cfg;
         end
         else if (wr_sw_w)
         begin
            src_reg <= wb_req_in.dat[2:0];
         end
      end
   end

   // lock clears on power-on and switch into a pll source; stale lock is not trusted
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         lock_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (load_w || (wr_sw_w && uses_pll(wb_req_in.dat[2:0])) || !uses_pll(src_reg))
         begin
            lock_reg <= 1'b0;
         end
         else if (pll_lock_sync_w && src_ready_w)
         begin
            lock_reg <= 1'b1;
         end
      end
   end

   assign wb_dat_out = dat_reg;
   assign wb_ack_out = ack_reg;
   assign rc_tune_out = tune_reg;

   // ***************************************************
   // rc postscaler and source routing
   // ***************************************************
   logic [7:0] post_cnt_reg;
   logic [7:0] post_last_w;
   logic [8:0] ratio_w;
   logic       post_tick_w;
   logic       rc_div16_w;

   // the div16 source ignores the select field
   assign rc_div16_w  = (src_reg == `OSR_SRC_RC_DIV16);
   assign ratio_w     = post_ratio(rc_div16_w ? `OSR_POST_DIV16_CODE : post_sel_reg);
   assign post_last_w = 8'(ratio_w - 9'h001);
   // >= keeps a shrinking ratio from running the count past its end
   assign post_tick_w = rc_edge_w && (post_cnt_reg >= post_last_w);

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         post_cnt_reg <= 8'h00;
      end
      else if (clk_en_in && rc_edge_w)
      begin
         post_cnt_reg <= post_tick_w ? 8'h00 : post_cnt_reg + 8'h01;
      end
   end

   logic sys_tick_w;
   logic pll_tick_w;
   logic pri_tick_w;

   assign pri_tick_w = pri_edge_w && pri_ready_w;

   // system and pll reference selection per source
   assign sys_tick_w = (src_reg == `OSR_SRC_RC)       ? rc_edge_w :
                       (src_reg == `OSR_SRC_RC_DIVN)  ? post_tick_w :
                       rc_div16_w                     ? post_tick_w :
                       (src_reg == `OSR_SRC_PRI)      ? pri_tick_w :
                       (src_reg == `OSR_SRC_SEC)      ? (sec_edge_w && sec_ready_w) : 1'b0;
   assign pll_tick_w = (src_reg == `OSR_SRC_RC_PLL)   ? post_tick_w :
                       (src_reg == `OSR_SRC_PRI_PLL)  ? pri_tick_w : 1'b0;

   // ready needs the timer on primary and secondary sources, and on pll sources the lock as well
   assign src_ready_w = (src_reg == `OSR_SRC_PRI || src_reg == `OSR_SRC_PRI_PLL) ? pri_ready_w :
                        (src_reg == `OSR_SRC_SEC) ? sec_ready_w : 1'b1;

   // ***************************************************
   // pin function selection
   // ***************************************************
   logic in_pin_out_next;
   logic in_pin_oe_n_next;
   logic out_pin_out_next;
   logic out_pin_oe_n_next;
   logic osc_output_pin_clk_w;

   assign osc_output_pin_clk_w = cfg_reg.osc_output_pin_pin_function_cfg;
   // input pin is port i/o only when the oscillator is off
   assign in_pin_out_next  = pri_off_w && osc_input_port_in.data;
   assign in_pin_oe_n_next = !(pri_off_w && osc_input_port_in.drive);
   // crystal owns the output pin; otherwise the function bit decides
   assign out_pin_out_next  = crystal_w ? 1'b0 :
                              osc_output_pin_clk_w ? instruction_clock_in : osc_output_port_in.data;
   assign out_pin_oe_n_next = crystal_w ? 1'b1 :
                              osc_output_pin_clk_w ? 1'b0 : !osc_output_port_in.drive;

   // registered outputs; pins stay released until config is loaded
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         osc_input_pin_out        <= 1'b0;
         osc_input_pin_oe_n_out   <= 1'b1;
         osc_output_pin_out       <= 1'b0;
         osc_output_pin_oe_n_out  <= 1'b1;
         osc_input_port_data_out  <= 1'b0;
         osc_output_port_data_out <= 1'b0;
         sys_clock_tick_out       <= 1'b0;
         pll_ref_tick_out         <= 1'b0;
         rc_post_tick_out         <= 1'b0;
         pll_path_out             <= 1'b0;
         clock_ready_out          <= 1'b0;
      end
      else if (clk_en_in)
      begin
         osc_input_pin_out        <= cfg_loaded_reg && in_pin_out_next;
         osc_input_pin_oe_n_out   <= !cfg_loaded_reg || in_pin_oe_n_next;
         osc_output_pin_out       <= cfg_loaded_reg && out_pin_out_next;
         osc_output_pin_oe_n_out  <= !cfg_loaded_reg || out_pin_oe_n_next;
         osc_input_port_data_out  <= pri_off_w && filt_reg[4];
         osc_output_port_data_out <= !crystal_w && filt_reg[5];
         sys_clock_tick_out       <= sys_tick_w;
         pll_ref_tick_out         <= pll_tick_w;
         rc_post_tick_out         <= post_tick_w;
         pll_path_out             <= uses_pll(src_reg);
         clock_ready_out          <= cfg_loaded_reg && src_ready_w && (!uses_pll(src_reg) || lock_reg);
      end
   end

   assign primary_ready_out   = pri_ready_w;
   assign secondary_ready_out = sec_ready_w;
   assign pll_lock_out        = lock_reg;

endmodule : osr_clock_front
`default_nettype wire

// ### osr_osc_src.sv
`timescale 1ns/1ps
`default_nettype none
module osr_osc_src
#(
   parameter int HALF_NS = 400
)
(
   // run control
   input wire logic run_in,
   // oscillator level
   output logic     osc_out
);
   // free-running, unrelated to the system clock; a stopped source stands still
   initial osc_out = 1'b0;
   always #(HALF_NS) osc_out = run_in ? ~osc_out : osc_out;
endmodule : osr_osc_src
`default_nettype wire

// ### osr_params.svh
`ifndef OSR_PARAMS_SVH
`define OSR_PARAMS_SVH

// ***************************************************
// start-up timer
// ***************************************************
`define OSR_STARTUP_CYCLES   1024
`define OSR_STARTUP_WIDTH    10

// ***************************************************
// primary oscillator modes and source codes
// ***************************************************
`define OSR_MODE_EXT         2'h0
`define OSR_MODE_MED         2'h1
`define OSR_MODE_HIGH        2'h2
`define OSR_MODE_OFF         2'h3
`define OSR_SRC_RC           3'h0
`define OSR_SRC_RC_PLL       3'h1
`define OSR_SRC_PRI          3'h2
`define OSR_SRC_PRI_PLL      3'h3
`define OSR_SRC_SEC          3'h4
`define OSR_SRC_RC_DIV16     3'h6
`define OSR_SRC_RC_DIVN      3'h7

// ***************************************************
// register map, fields and reset values
// ***************************************************
`define OSR_ADDR_CLOCK_DIVISOR_REG      8'h00
`define OSR_ADDR_TUNE        8'h04
`define OSR_ADDR_SWITCH      8'h08
`define OSR_ADDR_STATUS      8'h0c
`define OSR_POST_LSB         8
`define OSR_POST_MSB         10
`define OSR_POST_RESET       3'h0
`define OSR_POST_DIV16_CODE  3'h4
`define OSR_TUNE_MSB         5
`define OSR_TUNE_RESET       6'h00
`define OSR_TUNE_STEP_KHZ    30
`define OSR_ST_READY         0
`define OSR_ST_PRI_READY     1
`define OSR_ST_SEC_READY     2
`define OSR_ST_LOCK          3
`define OSR_ST_MODE_LSB      4
`define OSR_ST_OSC_OUTPUT_PIN_FN       6
`define OSR_ST_SRC_LSB       8
`define OSR_SYNC_STAGES      3

`endif

// ### osr_pkg.sv
`default_nettype none
package osr_pkg;

   // ***************************************************
   // carriers
   // ***************************************************
   // classic wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } osr_wb_req_s;

   // configuration words fixed at programming time
   typedef struct packed {
      logic [2:0]  initial_source_cfg;
      logic [1:0]  primary_osc_mode_cfg;
      logic        osc_output_pin_pin_function_cfg;
   } osr_cfg_s;

   // one digital port bit behind an oscillator pin
   typedef struct packed {
      logic        data;
      logic        drive;
   } osr_gpio_s;

endpackage : osr_pkg
`default_nettype wire

// ### osr_props.sv
`timescale 1ns/1ps
`default_nettype none
module osr_props
(
   // clock and reset
   input wire logic              clock_in,
   input wire logic              rst_n_in,
   // watched ports
   input wire osr_pkg::osr_cfg_s cfg_in,
   input wire logic              wb_ack_out,
   input wire logic              brown_out_in,
   input wire logic              sleep_in,
   input wire logic              instruction_clock_in,
   input wire logic              osc_input_pin_oe_n_out,
   input wire logic              osc_output_pin_oe_n_out,
   input wire logic              osc_output_pin_out,
   input wire logic              primary_ready_out,
   input wire logic              pll_path_out,
   input wire logic              pll_lock_out
);
   // ****************
   // properties
   // ****************
   wire logic [1:0] mode = cfg_in.primary_osc_mode_cfg;
   wire logic       xtal = mode inside {2'h1, 2'h2};
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // six clean cycles: config is loaded and the pins have taken their function
   sequence s_up; rst_n_in [*6]; endsequence
   property p_ack; wb_ack_out |=> !wb_ack_out; endproperty
   property p_xtal; s_up ##0 xtal |-> osc_input_pin_oe_n_out && osc_output_pin_oe_n_out; endproperty
   property p_ext; s_up ##0 mode == 2'h0 && !sleep_in |-> osc_input_pin_oe_n_out && primary_ready_out; endproperty
   property p_clk; s_up ##0 !xtal && cfg_in.osc_output_pin_pin_function_cfg |->
      !osc_output_pin_oe_n_out && osc_output_pin_out == $past(instruction_clock_in); endproperty
   property p_bor; brown_out_in && xtal |-> ##[1:2] !primary_ready_out; endproperty
   property p_hold; primary_ready_out && !brown_out_in && !sleep_in |=> primary_ready_out; endproperty
   // the path flag follows the source a cycle late, so the clear shows one edge earlier
   property p_sw; $rose(pll_path_out) |-> !$past(pll_lock_out); endproperty
   property p_off; !pll_path_out [*3] |-> !pll_lock_out; endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
   a_xtal: assert property (p_xtal) else $error("crystal pin driven");
   a_ext: assert property (p_ext) else $error("external clock held back");
   a_clk: assert property (p_clk) else $error("clock output wrong");
   a_bor: assert property (p_bor) else $error("brown-out did not rerun");
   a_hold: assert property (p_hold) else $error("ready dropped");
   a_sw: assert property (p_sw) else $error("lock kept over switch");
   a_off: assert property (p_off) else $error("lock without pll");
endmodule : osr_props
bind osr_clock_front osr_props i_props (.*);
`default_nettype wire

// ### osr_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "osr_params.svh"

module osr_startup_timer
#(
   parameter int unsigned CYCLES = `OSR_STARTUP_CYCLES
)
(
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   input  wire logic clk_en_in,
   // control
   input  wire logic enable_in,
   input  wire logic restart_in,
   input  wire logic bypass_in,
   input  wire logic osc_edge_in,
   // status
   output logic      ready_out
);

   localparam int unsigned W = $clog2(CYCLES);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   // a one-cycle count would release on noise alone
   if (CYCLES < 2)
   begin : g_bad_cycles
      $error("osr_startup_timer: CYCLES must be at least 2");
   end

   logic [W-1:0] count_reg;
   logic         ready_reg;

   // count qualified edges, then latch ready until disabled or restarted
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         count_reg <= '0;
         ready_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (!enable_in || restart_in)
         begin
            count_reg <= '0;
            ready_reg <= 1'b0;
         end
         else if (bypass_in)
         begin
            count_reg <= '0;
            ready_reg <= 1'b1;
         end
         else if (!ready_reg && osc_edge_in)
         begin
            if (count_reg == LAST)
            begin
               count_reg <= '0;
               ready_reg <= 1'b1;
            end
            else
            begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end

   assign ready_out = ready_reg;

endmodule : osr_startup_timer
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ****************
   // ports and models
   // ****************
   logic clock_in, rst_n_in, brown_out_in, pll_locked_in, secondary_enable_in, instruction_clock_in;
   logic clk_en_in, sleep_in;
   logic primary_osc_in, secondary_osc_in, rc_osc_in, run_p, run_s, wb_ack_out, sys_clock_tick_out;
   logic osc_input_pin_out, osc_input_pin_oe_n_out, osc_output_pin_out, osc_output_pin_oe_n_out;
   logic rc_post_tick_out, pll_path_out, clock_ready_out, primary_ready_out, secondary_ready_out, pll_lock_out;
   logic [5:0]  rc_tune_out;
   logic [31:0] wb_dat_out, rdat;
   int          n_errors = 0, checks = 0, n, t, u;
   osr_pkg::osr_wb_req_s wb_req_in;
   osr_pkg::osr_cfg_s    cfg_in;
   osr_pkg::osr_gpio_s   osc_input_port_in, osc_output_port_in;
   // a released input pin carries the primary oscillator; a released output pin shows the inverse of its level
   wire logic osc_input_pin_in = osc_input_pin_oe_n_out ? primary_osc_in : osc_input_pin_out;
   wire logic osc_output_pin_in = osc_output_pin_out ^ osc_output_pin_oe_n_out;
   osr_osc_src #(.HALF_NS(410)) i_pri (.run_in(run_p), .osc_out(primary_osc_in));
   osr_osc_src #(.HALF_NS(530)) i_sec (.run_in(run_s), .osc_out(secondary_osc_in));
   osr_osc_src #(.HALF_NS(350)) i_rc (.run_in(1'b1), .osc_out(rc_osc_in));
   // short start-up count keeps the run brief
   osr_clock_front #(.STARTUP_CYCLES(4)) i_dut (.*, .pll_ref_tick_out(),
      .osc_input_port_data_out(), .osc_output_port_data_out());
   initial
   begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   always @(posedge clock_in) instruction_clock_in <= ~instruction_clock_in;
   // ****************
   // tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // classic cycle: hold until ack is sampled, then release
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      wb_req_in <= '{1'b1, 1'b1, we, a, 4'hf, d};
      for (n = 0; n < 1 || (wb_ack_out !== 1'b1 && n < 20); n++) @(posedge clock_in);
      chk("ack", 32'(wb_ack_out), 32'h1);
      rdat = wb_dat_out;
      wb_req_in <= '0;
   endtask : bus
   task automatic restart(input osr_pkg::osr_cfg_s c);
      @(posedge clock_in);
      cfg_in <= c;
      rst_n_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (8) @(posedge clock_in);
   endtask : restart
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // ****************
   // tests
   // ****************
   initial
   begin
      {rst_n_in, brown_out_in, pll_locked_in, run_p, run_s, instruction_clock_in} = 6'h0;
      secondary_enable_in = 1'b1;
      {clk_en_in, sleep_in} = 2'h2;
      wb_req_in = '0;
      cfg_in = '0;
      osc_input_port_in = 2'h3;
      osc_output_port_in = 2'h3;
      // crystal: silence never counts, then a full count and a brown-out rerun
      restart(6'h15);
      repeat (40) @(posedge clock_in);
      chk("pri_silent", 32'(primary_ready_out), 32'h0);
      bus(1'b0, 8'h0c, 32'h0);
      chk("status", rdat & 32'h770, 32'h260);
      run_p <= 1'b1;
      for (n = 0; primary_ready_out !== 1'b1 && n < 400; n++) @(posedge clock_in);
      chk("pri_count", 32'(n >= 24 && n < 400), 32'h1);
      chk("sec_alone", 32'(secondary_ready_out), 32'h0);
      repeat (2) @(posedge clock_in);
      chk("clk_ready", 32'(clock_ready_out), 32'h1);
      brown_out_in <= 1'b1;
      @(posedge clock_in);
      brown_out_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk("bor_rerun", 32'(primary_ready_out), 32'h0);
      // a frozen block must not count oscillator edges
      clk_en_in <= 1'b0;
      repeat (60) @(posedge clock_in);
      chk("frozen", 32'(primary_ready_out), 32'h0);
      clk_en_in <= 1'b1;
      run_s <= 1'b1;
      for (n = 0; secondary_ready_out !== 1'b1 && n < 400; n++) @(posedge clock_in);
      chk("sec_count", 32'(n >= 30 && n < 400), 32'h1);
      repeat (40) @(posedge clock_in);
      chk("pri_back", 32'(primary_ready_out), 32'h1);
      // wake-up from sleep reruns both counts
      sleep_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      sleep_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk("wake_rerun", 32'({primary_ready_out, secondary_ready_out}), 32'h0);
      $display("crystal test done");
      // external clock with rc source: no counted delay, postscaler and tuning
      restart(6'h00);
      chk("ext_ready", 32'({primary_ready_out, clock_ready_out}), 32'h3);
      chk("osc_output_pin_io", 32'({osc_output_pin_oe_n_out, osc_output_pin_out}), 32'h1);
      bus(1'b0, 8'h00, 32'h0);
      chk("post_rst", 32'(rdat[10:8]), 32'h0);
      bus(1'b1, 8'h00, 32'h300);
      bus(1'b0, 8'h00, 32'h0);
      chk("post_rd", 32'(rdat[10:8]), 32'h3);
      t = 0;
      u = 0;
      repeat (600)
      begin
         @(posedge clock_in);
         t += int'(rc_post_tick_out);
         u += int'(sys_clock_tick_out);
      end
      chk("post_div8", 32'(t >= 9 && t <= 12), 32'h1);
      chk("sys_rc", 32'(u >= 80 && u <= 90), 32'h1);
      bus(1'b1, 8'h04, 32'hffff_ffea);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", rdat, 32'h0);
      chk("tune", 32'(rc_tune_out), 32'h2a);
      $display("external test done");
      // rc into pll, primary off: lock follows the path
      restart(6'h0f);
      chk("pins_off", 32'({pll_path_out, osc_input_pin_oe_n_out, pll_lock_out}), 32'h4);
      pll_locked_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      chk("locked", 32'({pll_lock_out, clock_ready_out}), 32'h3);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h100);
      chk("off_pll", 32'({pll_path_out, pll_lock_out}), 32'h0);
      bus(1'b1, 8'h08, 32'h1);
      repeat (8) @(posedge clock_in);
      chk("relock", 32'({pll_path_out, pll_lock_out}), 32'h3);
      $display("pll test done");
      tally_and_finish();
   end
   // the tests take about 950 cycles
   initial
   begin
      #1000000;
      n_errors++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
